// ---- rtl/shunt_power_calc_engine.sv ----
// Shunt power calculation engine: conversion sequencing, math, registers
`timescale 1ns/1ps

// How it works
// - Conversion time and averaging count are separate fields of setup.
// - Shunt and bus conversions each have their own time select.
// - Only shunt and bus voltages are measured; current, power derived.
// - Converter sample enable runs at 500 kHz from the system clock.
// - Current is shunt times scaling factor, divided by 2048.
// - Power is current times bus voltage, divided by 20000.
// - Power LSB is fixed at 25 current LSBs by the divider.
// - Current and power stay zero until scaling factor is written.
// - After programming, shunt results refresh current and bus results refresh power.
// - Only scaling factor and measured voltages feed the math.
// - Bus voltage register is 1.25 mV per count, as delivered.
// - Bus voltage register MSB always reads zero.
// - Current follows shunt conversion; power follows bus conversion.
// - Per-sample results accumulate; averages load after N samples.
module shunt_power_calc_engine
  import shunt_power_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Converter front end (decimator output, same clock)
  input  wire logic [15:0] shunt_meas,
  input  wire logic [15:0] bus_meas,
  output logic             sample_tick,
  output logic             conv_active,
  output logic             conv_bus_sel
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]        cfg;
    logic [15:0]        cal;
    logic               cal_set;
    logic [15:0]        shunt_reg;
    logic [15:0]        bus_reg;
    logic [15:0]        cur_reg;
    logic [15:0]        pwr_reg;
    logic [15:0]        rdata;
    logic [6:0]         tick_cnt;
    logic               sample_tick;
    phase_t             phase;
    logic               conv_active;
    logic               conv_bus;
    logic [12:0]        ct_cnt;
    logic [10:0]        avg_cnt;
    logic signed [15:0] last_cur;
    logic signed [15:0] last_pwr;
    logic signed [26:0] acc_sh;
    logic signed [26:0] acc_bus;
    logic signed [26:0] acc_cur;
    logic signed [26:0] acc_pwr;
  } state_t;

  localparam state_t ST_RST = '{cfg: CFG_RST, phase: PH_IDLE, default: '0};

  state_t s_r;
  state_t s_nxt;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [12:0] ct_ticks(input logic [2:0] sel);
    ct_ticks = 13'(CONV_US[sel] * (SAMPLE_HZ / 1000) / 1000);
  endfunction

  function automatic phase_t first_phase(input logic [15:0] cfg);
    if (cfg[MODE_SHUNT])
      first_phase = PH_SHUNT;
    else if (cfg[MODE_BUS])
      first_phase = PH_BUS;
    else
      first_phase = PH_IDLE;
  endfunction

  function automatic logic [15:0] avg_of(input logic signed [26:0] acc,
                                         input logic [2:0] sel);
    logic signed [26:0] q;
    q = acc >>> AVG_SHIFT[sel];
    avg_of = q[15:0];
  endfunction

  // --------------------------------------------------------------------------
  // Per-sample arithmetic
  // --------------------------------------------------------------------------
  // Full-width products so no intermediate can wrap; only the stored
  // quotient is cut to 16 bits.
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_quot;
  logic signed [15:0] cur_sample;
  logic signed [32:0] pwr_prod;
  logic signed [32:0] pwr_quot;
  logic signed [15:0] pwr_sample;
  logic [15:0]        bus_clean;

  always_comb begin
    cur_prod   = 33'(signed'(shunt_meas)) * 33'(signed'({1'b0, s_r.cal}));
    cur_quot   = cur_prod / 33'(CUR_DIV);
    cur_sample = cur_quot[15:0];
    bus_clean  = {1'b0, bus_meas[BUS_MSB-1:0]};
    // Dividing by 20000 fixes the power step at 25 current steps
    pwr_prod   = 33'(s_r.last_cur) * 33'(signed'({1'b0, bus_clean}));
    pwr_quot   = pwr_prod / 33'(PWR_DIV);
    pwr_sample = pwr_quot[15:0];
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic [2:0]  avg_sel;
  logic [10:0] avg_last;
  logic        sh_done;
  logic        bus_done;
  logic        round_done;

  always_comb begin
    s_nxt       = s_r;
    avg_sel     = s_r.cfg[CFG_AVG_LSB +: 3];
    avg_last    = 11'((1 << AVG_SHIFT[avg_sel]) - 1);
    // Conversion ends on a sample edge once its selected time elapsed
    sh_done     = s_r.phase == PH_SHUNT && s_r.sample_tick &&
                  s_r.ct_cnt == ct_ticks(s_r.cfg[CFG_SHCT_LSB +: 3]) - 13'd1;
    bus_done    = s_r.phase == PH_BUS && s_r.sample_tick &&
                  s_r.ct_cnt == ct_ticks(s_r.cfg[CFG_BUSCT_LSB +: 3]) - 13'd1;
    round_done  = bus_done || (sh_done && !s_r.cfg[MODE_BUS]);

    // 500 kHz sampling enable
    s_nxt.sample_tick = 1'b0;
    if (s_r.tick_cnt == 7'(TICK_DIV - 1)) begin
      s_nxt.tick_cnt    = '0;
      s_nxt.sample_tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 7'd1;
    end

    if (s_r.phase != PH_IDLE && s_r.sample_tick)
      s_nxt.ct_cnt = s_r.ct_cnt + 13'd1;

    // Shunt conversion result and current sample
    if (sh_done) begin
      s_nxt.ct_cnt   = '0;
      s_nxt.last_cur = s_r.cal_set ? cur_sample : 16'sh0000;
      s_nxt.acc_sh   = s_r.acc_sh + 27'(signed'(shunt_meas));
      s_nxt.acc_cur  = s_r.acc_cur +
                       27'(s_r.cal_set ? cur_sample : 16'sh0000);
      s_nxt.phase    = s_r.cfg[MODE_BUS] ? PH_BUS : PH_SHUNT;
    end

    // Bus conversion result and power from the latest current
    if (bus_done) begin
      s_nxt.ct_cnt   = '0;
      s_nxt.last_pwr = s_r.cal_set ? pwr_sample : 16'sh0000;
      s_nxt.acc_bus  = s_r.acc_bus + 27'(bus_clean);
      s_nxt.acc_pwr  = s_r.acc_pwr +
                       27'(s_r.cal_set ? pwr_sample : 16'sh0000);
      s_nxt.phase    = first_phase(s_r.cfg);
    end

    // One averaged sample complete
    if (round_done) begin
      s_nxt.avg_cnt = s_r.avg_cnt + 11'd1;
      if (s_r.avg_cnt == avg_last) begin
        // Sums still hold this sample here; clearing first would load zero
        s_nxt.avg_cnt = '0;
        if (s_r.cfg[MODE_SHUNT]) begin
          s_nxt.shunt_reg = avg_of(s_nxt.acc_sh, avg_sel);
          s_nxt.cur_reg   = s_r.cal_set ?
                            avg_of(s_nxt.acc_cur, avg_sel) : 16'h0000;
        end
        if (s_r.cfg[MODE_BUS]) begin
          s_nxt.bus_reg = avg_of(s_nxt.acc_bus, avg_sel) &
                          ~(16'h0001 << BUS_MSB);
          s_nxt.pwr_reg = s_r.cal_set ?
                          avg_of(s_nxt.acc_pwr, avg_sel) : 16'h0000;
        end
        s_nxt.acc_sh  = '0;
        s_nxt.acc_bus = '0;
        s_nxt.acc_cur = '0;
        s_nxt.acc_pwr = '0;
        // Triggered modes stop after one averaged result
        if (!s_r.cfg[MODE_CONT])
          s_nxt.phase = PH_IDLE;
      end
    end

    // Register port
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SETUP: s_nxt.rdata = s_r.cfg;
        ADDR_SHUNT: s_nxt.rdata = s_r.shunt_reg;
        ADDR_BUS:   s_nxt.rdata = s_r.bus_reg;
        ADDR_POWER: s_nxt.rdata = s_r.pwr_reg;
        ADDR_CURR:  s_nxt.rdata = s_r.cur_reg;
        ADDR_SCALE: s_nxt.rdata = s_r.cal;
        default:    s_nxt.rdata = 16'h0000;
      endcase
    end

    if (reg_wr && reg_addr == ADDR_SCALE) begin
      s_nxt.cal     = reg_wdata;
      s_nxt.cal_set = 1'b1;
    end

    // A setup write restarts the sequence with fresh accumulators
    if (reg_wr && reg_addr == ADDR_SETUP) begin
      s_nxt.cfg     = reg_wdata & ~(16'h0001 << CFG_SWRST_BIT);
      s_nxt.phase   = first_phase(reg_wdata);
      s_nxt.ct_cnt  = '0;
      s_nxt.avg_cnt = '0;
      s_nxt.acc_sh  = '0;
      s_nxt.acc_bus = '0;
      s_nxt.acc_cur = '0;
      s_nxt.acc_pwr = '0;
      if (reg_wdata[CFG_SWRST_BIT])
        s_nxt = ST_RST;
    end

    s_nxt.conv_active = s_nxt.phase != PH_IDLE;
    s_nxt.conv_bus    = s_nxt.phase == PH_BUS;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      s_r <= ST_RST;
    else
      s_r <= s_nxt;
  end

  assign reg_rdata    = s_r.rdata;
  assign sample_tick  = s_r.sample_tick;
  assign conv_active  = s_r.conv_active;
  assign conv_bus_sel = s_r.conv_bus;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_shunt_end;
    sh_done;
  endsequence

  sequence s_bus_end;
    bus_done;
  endsequence

  sequence s_avg_load;
    round_done && s_r.avg_cnt == avg_last && !(reg_wr && reg_addr == ADDR_SETUP);
  endsequence

  AST_BUS_MSB_ZERO: assert property (
    s_r.bus_reg[BUS_MSB] == 1'b0)
    else $error("bus voltage register MSB is set");

  AST_UNCAL_ZERO: assert property (
    !s_r.cal_set |-> s_r.cur_reg == 16'h0000 && s_r.pwr_reg == 16'h0000)
    else $error("current or power nonzero before scaling factor written");

  AST_TICK_PERIOD: assert property (
    sample_tick |-> $past(s_r.tick_cnt) == 7'(TICK_DIV - 1) &&
                    $past(s_r.tick_cnt, 2) == 7'(TICK_DIV - 2))
    else $error("sample enable not on the divider period");

  AST_CURRENT_MATH: assert property (
    s_shunt_end ##0 (s_r.cal_set && !reg_wr) |=>
      s_r.last_cur ==
        16'((33'(signed'($past(shunt_meas))) *
             33'(signed'({1'b0, s_r.cal}))) / 33'(CUR_DIV)))
    else $error("current sample not shunt times scale over 2048");

  AST_POWER_MATH: assert property (
    s_bus_end ##0 (s_r.cal_set && !reg_wr) |=>
      s_r.last_pwr ==
        16'((33'($past(s_r.last_cur)) *
             33'(signed'({2'b00, $past(bus_meas[BUS_MSB-1:0])}))) /
            33'(PWR_DIV)))
    else $error("power sample not current times bus over 20000");

  AST_POWER_AFTER_BUS: assert property (
    $changed(s_r.last_pwr) |-> $past(bus_done) || $past(reg_wr))
    else $error("power sample changed without a bus conversion");

  AST_LOAD_ONLY_AT_COUNT: assert property (
    ($changed(s_r.shunt_reg) || $changed(s_r.bus_reg)) |->
      $past(round_done && s_r.avg_cnt == avg_last) || $past(reg_wr))
    else $error("result registers loaded before averaging completed");

  AST_LOAD_CLEARS: assert property (
    s_avg_load |=> s_r.avg_cnt == '0 && s_r.acc_sh == '0)
    else $error("accumulators not cleared after an averaged load");

  AST_SHUNT_TIME: assert property (
    (s_r.phase == PH_SHUNT && s_r.ct_cnt == '0 && s_r.sample_tick &&
     s_r.cfg[CFG_SHCT_LSB +: 3] == 3'd0 && !reg_wr)
      ##1 (!reg_wr)[*8] |-> s_r.phase == PH_SHUNT)
    else $error("shunt conversion ended before its selected time");

endmodule // shunt_power_calc_engine

// ---- rtl/shunt_power_pkg.sv ----
// Constants, register map and types of the shunt power calculation engine
package shunt_power_pkg;

  // ------------------------------------------------------------------------
  // Clock and converter timing
  // ------------------------------------------------------------------------
  localparam int CLK_HZ    = 50_000_000;
  localparam int SAMPLE_HZ = 500_000;
  localparam int TICK_DIV  = CLK_HZ / SAMPLE_HZ;
  // Conversion times in microseconds, selected by a 3-bit field
  localparam int CONV_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  // Averaging counts 1,4,16,64,128,256,512,1024 as shift amounts
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // ------------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------------
  localparam logic [2:0] ADDR_SETUP = 3'h0;
  localparam logic [2:0] ADDR_SHUNT = 3'h1;
  localparam logic [2:0] ADDR_BUS   = 3'h2;
  localparam logic [2:0] ADDR_POWER = 3'h3;
  localparam logic [2:0] ADDR_CURR  = 3'h4;
  localparam logic [2:0] ADDR_SCALE = 3'h5;

  // ------------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------------
  localparam int CFG_SWRST_BIT = 15;
  localparam int CFG_AVG_LSB   = 9;
  localparam int CFG_BUSCT_LSB = 6;
  localparam int CFG_SHCT_LSB  = 3;
  localparam int MODE_SHUNT    = 0;
  localparam int MODE_BUS      = 1;
  localparam int MODE_CONT     = 2;
  localparam int BUS_MSB       = 15;
  localparam logic [15:0] CFG_RST = 16'h4127;

  // ------------------------------------------------------------------------
  // Arithmetic constants
  // ------------------------------------------------------------------------
  localparam int CUR_DIV = 2048;
  localparam int PWR_DIV = 20000;

  typedef enum logic [1:0] {PH_IDLE, PH_SHUNT, PH_BUS} phase_t;

endpackage

// ---- sim/host_model.sv ----
// Host side model: register port driver and scaling factor set-up
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [2:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 3'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Step rounded up to a round value trades a little resolution
  function automatic logic [15:0] calc_scale(real imax, real r_shunt);
    real step;
    step = $ceil(imax / 32768.0 * 1000.0) / 1000.0;
    return 16'(int'(0.00512 / (step * r_shunt)));
  endfunction

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Stale data would hide a late sample, so show its inverse
    reg_wdata = ~d;
  endtask

  // Data holds until the next read, so one spare cycle is safe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // host_model

// ---- sim/shunt_power_calc_engine_tb.sv ----
// Testbench of the shunt power calculation engine
`timescale 1ns/1ps
module shunt_power_calc_engine_tb
  import shunt_power_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic [2:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] shunt_meas;
  logic [15:0] bus_meas;
  logic        sample_tick;
  logic        conv_active;
  logic        conv_bus_sel;
  logic [15:0] v;
  int          fail_count;
  int          n_checks;
  int          seed;
  int          mdl [8];
  bit          cal_set;

  shunt_power_calc_engine dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shunt_meas(shunt_meas), .bus_meas(bus_meas),
    .sample_tick(sample_tick), .conv_active(conv_active),
    .conv_bus_sel(conv_bus_sel));

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // -------------------------------------------------------------------
  // Checking and closing
  // -------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Reference model
  // -------------------------------------------------------------------
  task automatic mwr(input logic [2:0] a, input logic [15:0] d);
    host.wr(a, d);
    if (a == ADDR_SETUP) mdl[0] = int'(d) & 32'h0000_7fff;
    if (a == ADDR_SETUP && d[15]) begin
      for (int i = 1; i < 8; i++) mdl[i] = 0;
      mdl[0]  = 32'h0000_4127;
      cal_set = 1'b0;
    end
    if (a == ADDR_SCALE) begin
      mdl[5] = int'(d);
      cal_set = 1'b1;
    end
  endtask

  task automatic check_regs;
    host.rd(ADDR_SHUNT, v);
    chk(v, 16'(mdl[1]));
    host.rd(ADDR_BUS, v);
    chk(v, 16'(mdl[2]));
    host.rd(ADDR_POWER, v);
    chk(v, 16'(mdl[3]));
    host.rd(ADDR_CURR, v);
    chk(v, 16'(mdl[4]));
    host.rd(ADDR_SCALE, v);
    chk(v, 16'(mdl[5]));
  endtask

  // One triggered round, one sample each of shunt and bus
  task automatic run_round(input logic [15:0] sh, input logic [15:0] bu);
    int k;
    int cur;
    shunt_meas = sh;
    bus_meas   = bu;
    mwr(ADDR_SETUP, 16'h0003);
    k = 0;
    while (sample_tick !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sample_tick !== 1'b1 && k < 200);
    chk(16'(k), 16'h0064);
    repeat (3400) @(negedge clk);
    chk(16'({conv_active, conv_bus_sel}), 16'h0002);
    repeat (7000) @(negedge clk);
    chk(16'({conv_active, conv_bus_sel}), 16'h0003);
    k = 0;
    while (conv_active !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(conv_active), 16'h0000);
    mdl[1] = int'(sh);
    mdl[2] = int'(bu) & 32'h0000_7fff;
    cur = cal_set ? (mdl[1] * mdl[5]) / 2048 : 0;
    mdl[4] = cur & 32'h0000_ffff;
    mdl[3] = ((cur * mdl[2]) / 20000) & 32'h0000_ffff;
    check_regs();
  endtask

  // Shunt-only triggered round of four samples, a fresh code per sample;
  // codes change mid-conversion so each one is taken exactly once
  task automatic avg_round(input logic [15:0] sh);
    int k;
    int acc;
    int cacc;
    logic [15:0] s;
    s          = sh;
    shunt_meas = s;
    acc        = int'(s);
    cacc       = (int'(s) * mdl[5]) / 2048;
    mwr(ADDR_SETUP, 16'h0201);
    repeat (3500) @(negedge clk);
    for (int i = 1; i < 4; i++) begin
      repeat (7000) @(negedge clk);
      chk(16'({conv_active, conv_bus_sel}), 16'h0002);
      s          = 16'($random(seed)) & 16'h3fff;
      shunt_meas = s;
      acc        = acc + int'(s);
      cacc       = cacc + (int'(s) * mdl[5]) / 2048;
    end
    k = 0;
    while (conv_active !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(conv_active), 16'h0000);
    mdl[1] = acc / 4;
    mdl[4] = cacc / 4;
    check_regs();
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    seed       = 75477;
    rst_b      = 1'b0;
    shunt_meas = 16'h0000;
    bus_meas   = 16'h0000;
    cal_set    = 1'b0;
    for (int a = 0; a < 8; a++) mdl[a] = 0;
    mdl[0] = 32'h0000_4127;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    host.rd(ADDR_SETUP, v);
    chk(v, 16'(mdl[0]));
    host.rd(ADDR_CURR, v);
    chk(v, 16'h0000);
    $display("test reset values done");
    run_round(16'h1f40, 16'ha570);
    host.rd(ADDR_SETUP, v);
    chk(v, 16'h0003);
    host.wr(ADDR_SHUNT, 16'hffff);
    host.rd(ADDR_SHUNT, v);
    chk(v, 16'(mdl[1]));
    host.rd(3'h6, v);
    chk(v, 16'h0000);
    $display("test before scaling done");
    v = host.calc_scale(15.0, 0.002);
    chk(v, 16'h0a00);
    mwr(ADDR_SCALE, v);
    run_round(16'h1f40, 16'ha570);
    $display("test worked example done");
    mwr(ADDR_SCALE, 16'($random(seed)) & 16'h0fff);
    run_round(16'($random(seed)) & 16'h3fff, 16'($random(seed)) & 16'h9fff);
    $display("test random round done");
    avg_round(16'($random(seed)) & 16'h3fff);
    $display("test averaging done");
    v = 16'($random(seed)) & 16'h3fff;
    shunt_meas = v;
    mdl[1] = int'(v);
    mdl[4] = (mdl[1] * mdl[5]) / 2048;
    mwr(ADDR_SETUP, 16'h0005);
    repeat (7100) @(negedge clk);
    chk(16'({conv_active, conv_bus_sel}), 16'h0002);
    check_regs();
    mwr(ADDR_SETUP, 16'h8000);
    chk(16'(conv_active), 16'h0000);
    check_regs();
    host.rd(ADDR_SETUP, v);
    chk(v, 16'(mdl[0]));
    $display("test continuous and soft reset done");
    test_done();
  end

  initial begin
    #2_000_000;
    fail_count++;
    test_done();
  end
endmodule // shunt_power_calc_engine_tb
